//--- core/dcd_pkg.sv
// Operation
// - Channel 0 source: low, high, 4-bit bank
// - Channel 0 destination: low, high, 4-bit bank
// - Alternation enable bit 7 resets to 0
// - Channel 0 end sets hand-off flop
// - Channel 1 end clears hand-off flop
// - Hand-off bit routes shared request 0/1
// - Hand-off toggles automatically, software may write
// - Bit 3: request input or timer output
// - Bits 2-0 with direction pick channel 1
// - Direction 0 codes select transmit-side sources
// - Direction 1 codes select receive-side sources
// - Transfer mode: 0 cycle-steal, 1 burst
`default_nettype none
package dcd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SRC_LOW = 8'h20;
  localparam logic [7:0] IDX_SRC_HIGH = 8'h21;
  localparam logic [7:0] IDX_SRC_BANK = 8'h22;
  localparam logic [7:0] IDX_DST_LOW = 8'h23;
  localparam logic [7:0] IDX_DST_HIGH = 8'h24;
  localparam logic [7:0] IDX_DST_BANK = 8'h25;
  localparam logic [7:0] IDX_COUNT0 = 8'h26;
  localparam logic [7:0] IDX_MEM1 = 8'h28;
  localparam logic [7:0] IDX_IO1 = 8'h2B;
  localparam logic [7:0] IDX_ROUTE1 = 8'h2D;
  localparam logic [7:0] IDX_COUNT1 = 8'h2E;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  localparam logic [7:0] IDX_MODE = 8'h31;
  localparam logic [7:0] IDX_CTRL = 8'h32;
  // Routing register fields
  localparam int RT_ALT = 7;
  localparam int RT_FF = 6;
  localparam int RT_PIN_OUT = 3;
  localparam logic [7:0] RT_MASK = 8'hCF;
  // Mode register fields
  localparam int MD_DM = 4;
  localparam int MD_SM = 2;
  localparam int MD_BURST = 1;
  // Control register fields
  localparam int CT_DIR1 = 1;
  localparam int CT_EN0 = 2;
  localparam int CT_EN1 = 3;
  localparam int CT_MODE1 = 4;
  // Status register fields
  localparam int ST_DONE0 = 0;
  localparam int ST_DONE1 = 1;
  localparam int ST_FF = 2;
  localparam int ST_PIN = 3;
  localparam int ST_PEND = 4;
  // Reset values
  localparam logic [19:0] RST_ADDR = 20'h00000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // Request select codes
  localparam logic [2:0] RQ_PIN = 3'h0;
  localparam logic [2:0] RQ_SER0 = 3'h1;
  localparam logic [2:0] RQ_SER1 = 3'h2;
  localparam logic [2:0] RQ_SYNC = 3'h3;
  localparam logic [2:0] RQ_PAR = 3'h7;
  // Address mode codes
  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_DEC = 2'h1;
  localparam logic [1:0] AM_FIX = 2'h2;
  localparam logic [1:0] AM_IO = 2'h3;
  localparam int BUF_WIDTH = 41;
endpackage
`default_nettype wire

//--- core/dcd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_sync
  import dcd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } dcd_sync_t;
  dcd_sync_t s_reg;
  dcd_sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.s1 = din;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    // Change taken only once stages two and three agree
    if (s_reg.s2 == s_reg.s3) begin
      s_next.q = s_reg.s3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.q;
endmodule
`default_nettype wire

//--- core/dcd_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } dcd_buf_t;
  dcd_buf_t b_reg;
  dcd_buf_t b_next;
  logic push;
  logic pop;

  assign in_ready = (b_reg.cnt != 2'h2);
  assign out_valid = (b_reg.cnt != 2'h0);
  assign out_data = b_reg.mem[b_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    b_next = b_reg;
    if (push) begin
      b_next.mem[b_reg.wr] = in_data;
      b_next.wr = ~b_reg.wr;
    end
    if (pop) begin
      b_next.rd = ~b_reg.rd;
    end
    b_next.cnt = b_reg.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_reg <= '0;
    end else if (ce) begin
      b_reg <= b_next;
    end
  end
endmodule
`default_nettype wire

//--- core/dcd_dma.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_dma
  import dcd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Request sources, same clock
  input wire logic ser0_tx_req,
  input wire logic ser0_rx_req,
  input wire logic ser1_tx_req,
  input wire logic ser1_rx_req,
  input wire logic sync_tx_req,
  input wire logic sync_rx_req,
  input wire logic par_out_req,
  input wire logic par_in_req,
  // Shared request / timer output pin
  input wire logic timer_out_or_request_pin_in,
  output logic timer_out_or_request_pin_out,
  output logic timer_out_or_request_pin_oe_n,
  input wire logic timer_one_out,
  input wire logic timer_one_drives_pin,
  // Transfer stream
  output logic xfer_valid,
  input wire logic xfer_ready,
  output logic xfer_chan,
  output logic [19:0] xfer_src,
  output logic [19:0] xfer_dst,
  output logic chan0_end,
  output logic chan1_end
);
  typedef struct packed {
    logic [19:0] sar0;
    logic [19:0] dar0;
    logic [15:0] cnt0;
    logic [19:0] chan1_memory_address;
    logic [15:0] chan1_io_address;
    logic [15:0] cnt1;
    logic [7:0] route;
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [1:0] done;
    logic gap;
    logic end0;
    logic end1;
    logic dsel;
    logic dwrite;
    logic [7:0] didx;
    logic [31:0] rdata;
  } dcd_state_t;
  dcd_state_t s_reg;
  dcd_state_t s_next;

  logic pin_level;
  logic buf_ready;
  logic [BUF_WIDTH-1:0] buf_word;
  logic [7:0] rx_vec;
  logic [7:0] tx_vec;
  logic [7:0] ch1_vec;
  logic pin_req;
  logic raw0;
  logic raw1;
  logic dev0;
  logic [3:0] id0;
  logic [3:0] id1;
  logic shared;
  logic req0;
  logic req1;
  logic go;
  logic use1;
  logic [1:0] sm;
  logic [1:0] dm;
  logic [1:0] md1;
  logic [19:0] src;
  logic [19:0] dst;
  logic [7:0] aidx;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////
  // Pin and request routing

  dcd_sync u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .din(timer_out_or_request_pin_in),
    .dout(pin_level)
  );

  // Pin drives only when set as output and timer owns it
  assign timer_out_or_request_pin_out = timer_one_out;
  assign timer_out_or_request_pin_oe_n =
    ~(s_reg.route[RT_PIN_OUT] && timer_one_drives_pin);
  // An output pin never raises a request
  assign pin_req = pin_level && !s_reg.route[RT_PIN_OUT];

  assign sm = s_reg.mode[MD_SM +: 2];
  assign dm = s_reg.mode[MD_DM +: 2];
  assign md1 = s_reg.ctrl[CT_MODE1 +: 2];

  always_comb begin
    rx_vec = 8'h00;
    tx_vec = 8'h00;
    rx_vec[RQ_PIN] = pin_req;
    rx_vec[RQ_SER0] = ser0_rx_req;
    rx_vec[RQ_SER1] = ser1_rx_req;
    rx_vec[RQ_SYNC] = sync_rx_req;
    rx_vec[RQ_PAR] = par_in_req;
    tx_vec[RQ_PIN] = pin_req;
    tx_vec[RQ_SER0] = ser0_tx_req;
    tx_vec[RQ_SER1] = ser1_tx_req;
    tx_vec[RQ_SYNC] = sync_tx_req;
    tx_vec[RQ_PAR] = par_out_req;
    ch1_vec = tx_vec;
    if (s_reg.ctrl[CT_DIR1]) begin
      ch1_vec = rx_vec;
      ch1_vec[RQ_SER1] = ser1_rx_req || pin_req;
    end
  end

  // Channel 0 paces on its I/O side; memory to memory runs free
  always_comb begin
    raw0 = 1'b1;
    dev0 = 1'b0;
    id0 = 4'h0;
    if (sm == AM_IO) begin
      raw0 = rx_vec[s_reg.sar0[18:16]];
      dev0 = 1'b1;
      id0 = {1'b1, s_reg.sar0[18:16]};
    end else if (dm == AM_IO) begin
      raw0 = tx_vec[s_reg.dar0[18:16]];
      dev0 = 1'b1;
      id0 = {1'b0, s_reg.dar0[18:16]};
    end
  end

  assign raw1 = ch1_vec[s_reg.route[2:0]];
  assign id1 = {s_reg.ctrl[CT_DIR1], s_reg.route[2:0]};
  assign shared = dev0 && (id0 == id1);

  // Shared requester seen by one channel only
  assign req0 = s_reg.ctrl[CT_EN0] && (s_reg.cnt0 != RST_COUNT) && raw0 &&
                !(shared && s_reg.route[RT_FF]);
  assign req1 = s_reg.ctrl[CT_EN1] && (s_reg.cnt1 != RST_COUNT) && raw1 &&
                !(shared && !s_reg.route[RT_FF]);
  // Cycle-steal leaves one idle cycle after each transfer
  assign go = (req0 || req1) && buf_ready && !s_reg.gap;
  assign use1 = !req0;

  always_comb begin
    src = s_reg.sar0;
    dst = s_reg.dar0;
    if (use1) begin
      if (md1[1]) begin
        src = {4'h0, s_reg.chan1_io_address};
        dst = s_reg.chan1_memory_address;
      end else begin
        src = s_reg.chan1_memory_address;
        dst = {4'h0, s_reg.chan1_io_address};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output buffer; a stalled receiver holds the engine

  dcd_buf2 #(
    .WIDTH(BUF_WIDTH)
  ) u_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .in_valid(go),
    .in_ready(buf_ready),
    .in_data({use1, src, dst}),
    .out_valid(xfer_valid),
    .out_ready(xfer_ready),
    .out_data(buf_word)
  );

  assign xfer_chan = buf_word[40];
  assign xfer_src = buf_word[39:20];
  assign xfer_dst = buf_word[19:0];

  ////////////////////////////////////////////////////////////////////
  // Register read mux

  assign aidx = haddr[9:2];

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (aidx)
      IDX_SRC_LOW: rd_mux[7:0] = s_reg.sar0[7:0];
      IDX_SRC_HIGH: rd_mux[7:0] = s_reg.sar0[15:8];
      IDX_SRC_BANK: rd_mux[3:0] = s_reg.sar0[19:16];
      IDX_DST_LOW: rd_mux[7:0] = s_reg.dar0[7:0];
      IDX_DST_HIGH: rd_mux[7:0] = s_reg.dar0[15:8];
      IDX_DST_BANK: rd_mux[3:0] = s_reg.dar0[19:16];
      IDX_COUNT0: rd_mux[15:0] = s_reg.cnt0;
      IDX_MEM1: rd_mux[19:0] = s_reg.chan1_memory_address;
      IDX_IO1: rd_mux[15:0] = s_reg.chan1_io_address;
      IDX_ROUTE1: rd_mux[7:0] = s_reg.route;
      IDX_COUNT1: rd_mux[15:0] = s_reg.cnt1;
      IDX_STATUS: begin
        rd_mux[ST_DONE1:ST_DONE0] = s_reg.done;
        rd_mux[ST_FF] = s_reg.route[RT_FF];
        rd_mux[ST_PIN] = pin_level;
        rd_mux[ST_PEND] = xfer_valid;
      end
      IDX_MODE: rd_mux[7:0] = s_reg.mode;
      IDX_CTRL: rd_mux[7:0] = s_reg.ctrl;
      default: rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;
    s_next.end0 = 1'b0;
    s_next.end1 = 1'b0;
    // Address phase capture; read data ready for the data phase
    if (hready) begin
      s_next.dsel = hsel && htrans[1];
      s_next.dwrite = hwrite;
      s_next.didx = aidx;
      if (hsel && htrans[1] && !hwrite) begin
        s_next.rdata = rd_mux;
      end
    end
    // Engine advance; hardware clear of enables comes before writes
    if (go) begin
      s_next.gap = !s_reg.mode[MD_BURST];
      if (!use1) begin
        s_next.cnt0 = s_reg.cnt0 - 16'h0001;
        unique case (sm)
          AM_INC: s_next.sar0 = s_reg.sar0 + 20'h00001;
          AM_DEC: s_next.sar0 = s_reg.sar0 - 20'h00001;
          AM_FIX, AM_IO: s_next.sar0 = s_reg.sar0;
        endcase
        unique case (dm)
          AM_INC: s_next.dar0 = s_reg.dar0 + 20'h00001;
          AM_DEC: s_next.dar0 = s_reg.dar0 - 20'h00001;
          AM_FIX, AM_IO: s_next.dar0 = s_reg.dar0;
        endcase
        if (s_reg.cnt0 == 16'h0001) begin
          s_next.end0 = 1'b1;
          s_next.ctrl[CT_EN0] = 1'b0;
        end
      end else begin
        s_next.cnt1 = s_reg.cnt1 - 16'h0001;
        if (md1[0]) begin
          s_next.chan1_memory_address = s_reg.chan1_memory_address - 20'h00001;
        end else begin
          s_next.chan1_memory_address = s_reg.chan1_memory_address + 20'h00001;
        end
        if (s_reg.cnt1 == 16'h0001) begin
          s_next.end1 = 1'b1;
          s_next.ctrl[CT_EN1] = 1'b0;
        end
      end
    end else begin
      s_next.gap = 1'b0;
    end
    // Data phase write; only the low lanes of a word are used
    if (s_reg.dsel && s_reg.dwrite) begin
      unique case (s_reg.didx)
        IDX_SRC_LOW: s_next.sar0[7:0] = hwdata[7:0];
        IDX_SRC_HIGH: s_next.sar0[15:8] = hwdata[7:0];
        IDX_SRC_BANK: s_next.sar0[19:16] = hwdata[3:0];
        IDX_DST_LOW: s_next.dar0[7:0] = hwdata[7:0];
        IDX_DST_HIGH: s_next.dar0[15:8] = hwdata[7:0];
        IDX_DST_BANK: s_next.dar0[19:16] = hwdata[3:0];
        IDX_COUNT0: s_next.cnt0 = hwdata[15:0];
        IDX_MEM1: s_next.chan1_memory_address = hwdata[19:0];
        IDX_IO1: s_next.chan1_io_address = hwdata[15:0];
        // Reserved bits 5-4 are not stored and read as zero
        IDX_ROUTE1: s_next.route = hwdata[7:0] & RT_MASK;
        IDX_COUNT1: s_next.cnt1 = hwdata[15:0];
        IDX_STATUS: s_next.done = s_reg.done & ~hwdata[ST_DONE1:ST_DONE0];
        IDX_MODE: s_next.mode = hwdata[7:0];
        IDX_CTRL: s_next.ctrl = hwdata[7:0];
        default: s_next.ctrl = s_next.ctrl;
      endcase
    end
    // Hardware events win over a software clear or write
    if (s_next.end0) begin
      s_next.done[0] = 1'b1;
      if (s_reg.route[RT_ALT]) begin
        s_next.route[RT_FF] = 1'b1;
      end
    end
    if (s_next.end1) begin
      s_next.done[1] = 1'b1;
      if (s_reg.route[RT_ALT]) begin
        s_next.route[RT_FF] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.sar0 <= RST_ADDR;
      s_reg.dar0 <= RST_ADDR;
      s_reg.chan1_memory_address <= RST_ADDR;
      s_reg.cnt0 <= RST_COUNT;
      s_reg.cnt1 <= RST_COUNT;
      s_reg.route <= RST_ROUTE;
      s_reg.mode <= RST_MODE;
      s_reg.ctrl <= RST_CTRL;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Zero wait states; every access answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign chan0_end = s_reg.end0;
  assign chan1_end = s_reg.end1;
endmodule
`default_nettype wire

//--- bench/dcd_far.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_far (
  input wire logic hclk,
  input wire logic [8:0] req,
  input wire logic stall,
  output logic ser0_tx_req,
  output logic ser0_rx_req,
  output logic ser1_tx_req,
  output logic ser1_rx_req,
  output logic sync_tx_req,
  output logic sync_rx_req,
  output logic par_out_req,
  output logic par_in_req,
  output logic timer_out_or_request_pin_in,
  input wire logic timer_out_or_request_pin_out,
  input wire logic timer_out_or_request_pin_oe_n,
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire logic xfer_chan,
  input wire logic [19:0] xfer_src,
  input wire logic [19:0] xfer_dst
);
  logic [40:0] got[$];
  int tm[$];
  int cyc = 0;
  assign {par_in_req, par_out_req, sync_rx_req, sync_tx_req} = req[7:4];
  assign {ser1_rx_req, ser1_tx_req, ser0_rx_req, ser0_tx_req} = req[3:0];
  // Wire level: the block wins while it drives the pin
  assign timer_out_or_request_pin_in =
    timer_out_or_request_pin_oe_n ? req[8] : timer_out_or_request_pin_out;
  assign xfer_ready = !stall;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (xfer_valid && xfer_ready) begin
      got.push_back({xfer_chan, xfer_src, xfer_dst});
      tm.push_back(cyc);
    end
  end
endmodule
`default_nettype wire

//--- bench/dcd_dma_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_dma_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic timer_out_or_request_pin_out,
  input wire logic timer_out_or_request_pin_oe_n,
  input wire logic timer_one_out,
  input wire logic timer_one_drives_pin,
  input wire logic xfer_valid,
  input wire logic xfer_ready,
  input wire logic xfer_chan,
  input wire logic [19:0] xfer_src,
  input wire logic [19:0] xfer_dst,
  input wire logic chan0_end,
  input wire logic chan1_end
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////
  sequence s_end0; xfer_valid ##1 !chan0_end; endsequence
  sequence s_end1; xfer_valid ##1 !chan1_end; endsequence
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer bad");
  property p_stall; xfer_valid && !xfer_ready |=> xfer_valid &&
    $stable({xfer_chan, xfer_src, xfer_dst}); endproperty
  a_stall: assert property (p_stall) else $error("stalled word changed");
  property p_drop; $fell(xfer_valid) |-> $past(xfer_ready); endproperty
  a_drop: assert property (p_drop) else $error("word lost");
  property p_end0; chan0_end |-> s_end0; endproperty
  a_end0: assert property (p_end0) else $error("channel 0 end bad");
  property p_end1; chan1_end |-> s_end1; endproperty
  a_end1: assert property (p_end1) else $error("channel 1 end bad");
  property p_excl; !(chan0_end && chan1_end); endproperty
  a_excl: assert property (p_excl) else $error("both channels ended");
  property p_oe; !timer_one_drives_pin |-> timer_out_or_request_pin_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("pin driven");
  property p_out; timer_out_or_request_pin_out == timer_one_out; endproperty
  a_out: assert property (p_out) else $error("pin value bad");
endmodule
`default_nettype wire

//--- bench/dcd_dma_test.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_dma_test
  import dcd_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic hready, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic ser0_tx_req, ser0_rx_req, ser1_tx_req, ser1_rx_req;
  logic sync_tx_req, sync_rx_req, par_out_req, par_in_req;
  logic timer_out_or_request_pin_in, timer_out_or_request_pin_out;
  logic timer_out_or_request_pin_oe_n, timer_one_out = 1'b0, timer_one_drives_pin = 1'b0;
  logic xfer_valid, xfer_ready, xfer_chan, chan0_end, chan1_end, stall = 0;
  logic [19:0] xfer_src, xfer_dst;
  logic [8:0] req = 9'h0;
  int fail_count = 0, total_checks = 0;
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  dcd_dma i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ser0_tx_req(ser0_tx_req), .ser0_rx_req(ser0_rx_req),
    .ser1_tx_req(ser1_tx_req), .ser1_rx_req(ser1_rx_req),
    .sync_tx_req(sync_tx_req), .sync_rx_req(sync_rx_req),
    .par_out_req(par_out_req), .par_in_req(par_in_req),
    .timer_out_or_request_pin_in(timer_out_or_request_pin_in),
    .timer_out_or_request_pin_out(timer_out_or_request_pin_out),
    .timer_out_or_request_pin_oe_n(timer_out_or_request_pin_oe_n),
    .timer_one_out(timer_one_out), .timer_one_drives_pin(timer_one_drives_pin),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_chan(xfer_chan),
    .xfer_src(xfer_src), .xfer_dst(xfer_dst),
    .chan0_end(chan0_end), .chan1_end(chan1_end)
  );
  dcd_far i_far (
    .hclk(hclk), .req(req), .stall(stall),
    .ser0_tx_req(ser0_tx_req), .ser0_rx_req(ser0_rx_req),
    .ser1_tx_req(ser1_tx_req), .ser1_rx_req(ser1_rx_req),
    .sync_tx_req(sync_tx_req), .sync_rx_req(sync_rx_req),
    .par_out_req(par_out_req), .par_in_req(par_in_req),
    .timer_out_or_request_pin_in(timer_out_or_request_pin_in),
    .timer_out_or_request_pin_out(timer_out_or_request_pin_out),
    .timer_out_or_request_pin_oe_n(timer_out_or_request_pin_oe_n),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_chan(xfer_chan),
    .xfer_src(xfer_src), .xfer_dst(xfer_dst)
  );
  ////////////////////////////////
  task automatic stop_test;
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [40:0] e, logic [40:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdy;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      stop_test;
    end
  endtask
  task automatic bus(logic w, logic [7:0] ix, logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic wr(logic [7:0] ix, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ix, d, q);
  endtask
  task automatic rc(logic [7:0] ix, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ix, 32'h0, q);
    chk($sformatf("reg %h", ix), 41'(e), 41'(q));
  endtask
  // Bounded: a stuck engine must still reach the verdict
  task automatic wt(int k);
    int n = 0;
    while (i_far.got.size() < k && n < 300) begin
      @(posedge hclk);
      n++;
    end
    if (i_far.got.size() < k) begin
      fail_count++;
      stop_test;
    end
  endtask
  task automatic wc(logic c, logic [19:0] s, logic [19:0] d);
    chk("word", {c, s, d}, i_far.got.pop_front());
  endtask
  task automatic sa(logic [19:0] s, logic [19:0] d);
    logic [19:0] a;
    for (int i = 0; i < 6; i++) begin
      a = i < 3 ? s : d;
      wr(IDX_SRC_LOW + 8'(i), 32'(a >> (8 * (i % 3))) & 32'hFF);
    end
  endtask
  ////////////////////////////////
  task automatic t_regs;
    rc(IDX_ROUTE1, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rc(IDX_SRC_LOW + 8'(i), 32'h0);
      wr(IDX_SRC_LOW + 8'(i), 32'hFFFFFF5A);
      rc(IDX_SRC_LOW + 8'(i), i % 3 == 2 ? 32'hA : 32'h5A);
    end
    wr(8'hFF, 32'h1);
    rc(8'hFF, 32'h0);
  endtask
  task automatic t_ch0;
    int g1, g2;
    logic [19:0] ss, sd;
    for (int m = 0; m < 3; m++) begin
      sa(20'h51234, 20'h6ABCD);
      wr(IDX_MODE, 32'((2 - m) * 16 + m * 4 + (m > 0) * 2));
      ss = m == 0 ? 20'h1 : (m == 1 ? 20'hFFFFF : 20'h0);
      sd = m == 2 ? 20'h1 : (m == 1 ? 20'hFFFFF : 20'h0);
      stall <= m == 2;
      wr(IDX_COUNT0, 32'h3);
      wr(IDX_CTRL, 32'h4);
      if (m == 2) begin
        repeat (10) @(posedge hclk);
        chk("stalled", 41'h0, 41'(i_far.got.size()));
        stall <= 1'b0;
      end
      wt(3);
      g1 = i_far.tm[1] - i_far.tm[0];
      g2 = i_far.tm[2] - i_far.tm[1];
      if (m < 2) chk("gap", 41'h1, 41'(m ? g1 == 1 && g2 == 1 : g1 > 1 && g2 > 1));
      i_far.tm.delete();
      for (int k = 0; k < 3; k++) begin
        wc(1'b0, 20'(20'h51234 + ss * k), 20'(20'h6ABCD + sd * k));
      end
    end
  endtask
  task automatic t_ch1;
    logic [2:0] cs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    int b;
    for (int d = 0; d < 2; d++) begin
      for (int j = 0; j < 5; j++) begin
        b = cs[j] == 0 ? 8 : d + (cs[j] == 7 ? 6 : 2 * cs[j] - 2);
        req <= 9'h0FF & ~(9'h1 << b);
        wr(IDX_ROUTE1, 32'(cs[j]));
        wr(IDX_MEM1, 32'h12345);
        wr(IDX_IO1, 32'hABC);
        wr(IDX_COUNT1, 32'h1);
        // Odd passes use the decrementing channel 1 modes
        wr(IDX_CTRL, 32'(8 + 34 * d + 16 * (j % 2)));
        repeat (8) @(posedge hclk);
        chk("unrouted", 41'h0, 41'(i_far.got.size()));
        req <= 9'h1 << b;
        if (j == 1) begin
          // Enable low must hold off a pending request
          ce <= 1'b0;
          repeat (6) @(posedge hclk);
          chk("frozen", 41'h0, 41'(i_far.got.size()));
          ce <= 1'b1;
        end
        wt(1);
        wc(1'b1, d ? 20'hABC : 20'h12345, d ? 20'h12345 : 20'hABC);
        rc(IDX_MEM1, j % 2 ? 32'h12344 : 32'h12346);
      end
    end
    req <= 9'h0;
  endtask
  task automatic t_alt;
    sa(20'h11234, 20'h6ABCD);
    wr(IDX_MODE, 32'h2C);
    wr(IDX_COUNT0, 32'h1);
    wr(IDX_COUNT1, 32'h1);
    wr(IDX_MEM1, 32'h12345);
    wr(IDX_IO1, 32'hABC);
    wr(IDX_ROUTE1, 32'h41);
    req <= 9'h2;
    wr(IDX_CTRL, 32'h2E);
    wt(1);
    wc(1'b1, 20'hABC, 20'h12345);
    repeat (8) @(posedge hclk);
    chk("hidden", 41'h0, 41'(i_far.got.size()));
    rc(IDX_ROUTE1, 32'h41);
    wr(IDX_ROUTE1, 32'h81);
    wt(1);
    wc(1'b0, 20'h11234, 20'h6ABCD);
    rc(IDX_ROUTE1, 32'hC1);
    wr(IDX_MEM1, 32'h12345);
    wr(IDX_COUNT1, 32'h1);
    wr(IDX_CTRL, 32'h2A);
    wt(1);
    wc(1'b1, 20'hABC, 20'h12345);
    rc(IDX_ROUTE1, 32'h81);
    req <= 9'h0;
    rc(IDX_STATUS, 32'h3);
    wr(IDX_STATUS, 32'h3);
    rc(IDX_STATUS, 32'h0);
  endtask
  task automatic t_pin;
    wr(IDX_ROUTE1, 32'h8);
    rc(IDX_ROUTE1, 32'h8);
    for (int v = 0; v < 2; v++) begin
      @(posedge hclk);
      timer_one_drives_pin <= 1'b1;
      timer_one_out <= v[0];
      @(negedge hclk);
      chk("pin out", 41'(v), 41'(timer_out_or_request_pin_out));
      chk("pin oe", 41'h0, 41'(timer_out_or_request_pin_oe_n));
    end
    wr(IDX_ROUTE1, 32'h0);
    @(negedge hclk);
    chk("pin oe", 41'h1, 41'(timer_out_or_request_pin_oe_n));
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_ch0;
    t_ch1;
    t_alt;
    t_pin;
    stop_test;
  end
endmodule
bind dcd_dma dcd_dma_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .timer_out_or_request_pin_out(timer_out_or_request_pin_out),
  .timer_out_or_request_pin_oe_n(timer_out_or_request_pin_oe_n),
  .timer_one_out(timer_one_out), .timer_one_drives_pin(timer_one_drives_pin),
  .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_chan(xfer_chan),
  .xfer_src(xfer_src), .xfer_dst(xfer_dst),
  .chan0_end(chan0_end), .chan1_end(chan1_end)
);
`default_nettype wire
